// >>> sleep_wake_pkg.sv
/*
 Package for the sleep/wake controller: register map, field positions,
 reset values, state codes and carrier structs.
 Assumes a 32-bit AXI4-Lite register bus and a single 10 MHz clock.
*/
package sleep_wake_pkg;
   // Register byte offsets
   localparam logic [7:0] OFF_OPTION = 8'h00; // Option control
   localparam logic [7:0] OFF_STATUS = 8'h04; // Power-down/time-out flags, state
   localparam logic [7:0] OFF_IRQEN = 8'h08; // Individual enables plus global
   localparam logic [7:0] OFF_IRQFLAG = 8'h0C; // Sticky interrupt flags
   localparam logic [7:0] OFF_PROG = 8'h10; // Programming status
   // Option control reset value
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   // Field positions
   localparam int STAT_PD_BIT = 0; // Power-down flag
   localparam int STAT_TO_BIT = 1; // Time-out flag
   localparam int GIE_BIT = 7; // Global enable within enables word
   localparam int PROG_MODE_BIT = 0; // Program/verify mode
   localparam int PROG_CP_BIT = 1; // Code protect state
   // Wake source indices
   localparam int NSRC = 6; // Timer1 async, capture, adc-rc, comparator, change, int pin
   localparam int SRC_INT = 5; // External interrupt pin
   // Response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Oscillator restart time and derived cycle count
   localparam int OSC_START_NS = 1000;
   localparam int CLK_NS = 100;
   localparam int OSC_START_CYC = (OSC_START_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [7:0] OSC_START_CNT = 8'(OSC_START_CYC);
   // Interrupt vector address
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   // ID locations
   localparam logic [13:0] ID_BASE = 14'h2000;
   localparam logic [13:0] ID_LAST = 14'h2003;
   // Controller states
   typedef enum logic [3:0] {
      ST_RUN = 4'b0001,
      ST_SLEEP = 4'b0010,
      ST_OSCUP = 4'b0100,
      ST_RESUME = 4'b1000
   } pstate_t;
   // Core-side request carrier
   typedef struct packed {
      logic sleepInstr; // Sleep instruction executing
      logic wdtClearInstr; // Watchdog clear instruction
      logic [12:0] pc; // Address of the sleep instruction
   } core_req_t;
   // Core-side answer carrier
   typedef struct packed {
      logic resumeStrobe; // Resume execution pulse
      logic vectorTake; // Branch to interrupt vector after next instruction
      logic [12:0] prefetchAddr; // Address prefetched during sleep
      logic [12:0] vectorAddr; // Interrupt vector
   } core_ans_t;
endpackage : sleep_wake_pkg

// >>> sleep_wake_controller.sv
/*
 Sleep entry and wake control with watchdog clear, power-down and
 time-out flags, interrupt wake gating and program/verify entry.
 Assumes synchronous pin inputs, a watchdog counter outside that obeys
 the clear pulse, and a core that stalls until resume.
*/
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
module sleep_wake_controller
   import sleep_wake_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Asynchronous reset, active low
   input wire core_req_t coreReq, // Core instruction requests
   output core_ans_t coreAns, // Answers to the core
   input wire logic [NSRC-1:0] wakeEvent, // Async-capable peripheral events
   input wire logic [NSRC-1:0] clockedEvent, // Events needing a running clock
   input wire logic wdtTimeout, // Watchdog expiry
   input wire logic watchdog_enable_fuse, // Watchdog enable fuse
   input wire logic master_clear_pin, // Master clear level, active low
   input wire logic high_voltage_entry_level, // Master clear at high voltage
   input wire logic serial_prog_data, // Programming data in
   input wire logic serial_prog_clock, // Programming clock in
   input wire logic code_protect_bit, // Code protect fuse, 1 = unprotected
   input wire logic protectOffReq, // Programmer turns protection off
   input wire logic [13:0] progAddr, // Programmer address
   input wire logic [13:0] progWdata, // Programmer write data
   input wire logic progWrite, // Programmer write strobe
   input wire logic [13:0] flashRdata, // Program memory read data
   output logic [13:0] progRdata, // Programmer read data
   output logic progDataOut, // Serial data drive value
   output logic progDataOe, // Serial data drive enable
   output logic bulkErase, // Erase whole flash
   output logic wdtClear, // Clear watchdog and scalers
   output logic oscRun, // Oscillator driver on
   output logic pinHold, // Hold I/O drive states
   output logic deviceReset, // Full device reset request
   output logic masterClearOut, // Master clear drive value
   output logic masterClearOe, // Master clear drive enable
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   pstate_t state_reg; // Controller state
   logic [7:0] option_control_reg; // Option control
   logic power_down_flag_reg; // Power-down flag
   logic timeout_flag_reg; // Time-out flag
   logic [NSRC-1:0] irqEn_reg; // Individual enables
   logic global_irq_enable_reg; // Global enable
   logic [NSRC-1:0] irqFlag_reg; // Sticky flags
   logic [7:0] oscCnt_reg; // Oscillator restart count
   logic [12:0] prefetch_reg; // Prefetched address
   logic progMode_reg; // Program/verify mode
   logic hvPrev_reg; // Last high-voltage level
   logic [13:0] idMem_reg [4]; // ID locations
   logic awHave_reg; // Address taken
   logic wHave_reg; // Data taken
   logic [7:0] awAddr_reg; // Latched write address
   logic [31:0] wData_reg; // Latched write data
   logic [3:0] wStrb_reg; // Latched strobes
   logic [NSRC-1:0] flagClr; // Flag clear from bus
   logic pending; // Enabled flag set
   logic wakeIrq; // Interrupt wake now
   logic wdtWake; // Watchdog wake now
   logic mclrAsserted; // Master clear low
   logic sleepOk; // Sleep not a no-op
   logic wrFire; // Write completes
   logic isId; // Programmer address in ID range

   // Byte-lane merge of a write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////
   // Wake decoding
   always_comb begin
      // Clocked sources only count while running
      pending = |(irqFlag_reg & irqEn_reg);
      mclrAsserted = !master_clear_pin;
      wdtWake = watchdog_enable_fuse && wdtTimeout && (state_reg == ST_SLEEP);
      wakeIrq = (state_reg == ST_SLEEP) && pending;
      sleepOk = coreReq.sleepInstr && (state_reg == ST_RUN) && !pending;
      isId = (progAddr >= ID_BASE) && (progAddr <= ID_LAST);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state machine
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= ST_RUN;
         oscCnt_reg <= '0;
      end else begin
         unique case (state_reg)
            ST_RUN: begin
               // Enter power-down on sleep instruction
               if (sleepOk && !mclrAsserted) begin
                  state_reg <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               // Master clear, watchdog time-out or an enabled pending flag ends sleep
               if (mclrAsserted) begin
                  state_reg <= ST_RUN;
               end else if (wdtWake || wakeIrq) begin
                  state_reg <= ST_OSCUP;
                  oscCnt_reg <= OSC_START_CNT;
               end
            end
            ST_OSCUP: begin
               // Oscillator settles before execution
               if (oscCnt_reg == 8'h01) begin
                  state_reg <= ST_RESUME;
               end
               oscCnt_reg <= oscCnt_reg - 8'h01;
            end
            ST_RESUME: begin
               state_reg <= ST_RUN;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sleep side effects and core answer
   always_comb begin
      oscRun = (state_reg != ST_SLEEP);
      pinHold = (state_reg == ST_SLEEP) || (state_reg == ST_OSCUP);
      // Clear on entry, on wake exit through resume and on the clear instruction
      wdtClear = sleepOk || (state_reg == ST_RESUME) || coreReq.wdtClearInstr;
      deviceReset = (state_reg == ST_SLEEP) && mclrAsserted;
      masterClearOut = 1'b0; // Never pulled low, even on watchdog reset
      masterClearOe = 1'b0;
   end

   // Resume answer registered
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         coreAns <= '0;
         prefetch_reg <= '0;
      end else begin
         if (sleepOk) begin
            prefetch_reg <= coreReq.pc + 13'h0001;
         end
         coreAns.resumeStrobe <= (state_reg == ST_RESUME);
         coreAns.vectorTake <= (state_reg == ST_RESUME) && global_irq_enable_reg && pending;
         coreAns.prefetchAddr <= prefetch_reg;
         coreAns.vectorAddr <= IRQ_VECTOR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         power_down_flag_reg <= 1'b1;
         timeout_flag_reg <= 1'b1;
      end else begin
         if (wdtWake) begin
            timeout_flag_reg <= 1'b0;
         end else if (sleepOk) begin
            power_down_flag_reg <= 1'b0;
            timeout_flag_reg <= 1'b1;
         end else if (coreReq.wdtClearInstr) begin
            power_down_flag_reg <= 1'b1;
            timeout_flag_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt flags: set wins over clear
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         irqFlag_reg <= '0;
      end else if (state_reg == ST_SLEEP) begin
         irqFlag_reg <= irqFlag_reg | wakeEvent;
      end else begin
         irqFlag_reg <= (irqFlag_reg & ~flagClr) | wakeEvent | clockedEvent;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Program/verify mode and ID locations
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         progMode_reg <= 1'b0;
         hvPrev_reg <= 1'b0;
      end else begin
         hvPrev_reg <= high_voltage_entry_level;
         // Entry on rising high voltage with both serial pins low
         if (high_voltage_entry_level && !hvPrev_reg && !serial_prog_data && !serial_prog_clock) begin
            progMode_reg <= 1'b1;
         end else if (!high_voltage_entry_level) begin
            progMode_reg <= 1'b0;
         end
      end
   end

   // ID words written only in program mode
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < 4; i++) begin
            idMem_reg[i] <= '0;
         end
      end else if (progMode_reg && progWrite && isId) begin
         idMem_reg[progAddr[1:0]] <= progWdata;
      end
   end

   // Programmer read data and erase
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         progRdata <= '0;
         bulkErase <= 1'b0;
      end else begin
         bulkErase <= progMode_reg && protectOffReq;
         if (!progMode_reg) begin
            progRdata <= '0;
         end else if (isId) begin
            progRdata <= idMem_reg[progAddr[1:0]];
         end else if (code_protect_bit) begin
            progRdata <= flashRdata;
         end else begin
            progRdata <= '0;
         end
      end
   end

   // Bit 0 of read data driven on the data pin while the serial clock is low
   always_comb begin
      progDataOe = progMode_reg && !serial_prog_clock;
      progDataOut = progRdata[0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
   assign s_axi_wready = !wHave_reg && !s_axi_bvalid;
   assign wrFire = awHave_reg && wHave_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         awHave_reg <= 1'b0;
         wHave_reg <= 1'b0;
         awAddr_reg <= '0;
         wData_reg <= '0;
         wStrb_reg <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (wrFire) begin
            awHave_reg <= 1'b0;
            wHave_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr_reg inside {OFF_OPTION, OFF_STATUS, OFF_IRQEN, OFF_IRQFLAG, OFF_PROG})
                           ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Writable registers
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         option_control_reg <= OPTION_RESET;
         irqEn_reg <= '0;
         global_irq_enable_reg <= 1'b0;
      end else if (wrFire) begin
         if (awAddr_reg == OFF_OPTION) begin
            option_control_reg <= 8'(merge(32'(option_control_reg), wData_reg, wStrb_reg));
         end
         if (awAddr_reg == OFF_IRQEN) begin
            irqEn_reg <= wStrb_reg[0] ? wData_reg[NSRC-1:0] : irqEn_reg;
            global_irq_enable_reg <= wStrb_reg[0] ? wData_reg[GIE_BIT] : global_irq_enable_reg;
         end
      end
   end

   // Write-one-to-clear of flags
   assign flagClr = (wrFire && awAddr_reg == OFF_IRQFLAG && wStrb_reg[0]) ? wData_reg[NSRC-1:0] : '0;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         unique case (s_axi_araddr)
            OFF_OPTION: s_axi_rdata <= {24'h00_0000, option_control_reg};
            OFF_STATUS: s_axi_rdata <= {24'h00_0000, state_reg, 2'b00, timeout_flag_reg, power_down_flag_reg};
            OFF_IRQEN: s_axi_rdata <= {24'h00_0000, global_irq_enable_reg, 1'b0, irqEn_reg};
            OFF_IRQFLAG: s_axi_rdata <= {26'h000_0000, irqFlag_reg};
            OFF_PROG: s_axi_rdata <= {30'h0000_0000, code_protect_bit, progMode_reg};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : sleep_wake_controller

// >>> sleep_wake_monitor.sv
/*
 Checker for the sleep/wake controller, watching only its top ports.
 Assumes a bind from the testbench and the single clk_sys domain.
*/
`timescale 1ns/10ps
module sleep_wake_monitor
   import sleep_wake_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic reset_n, // Reset, active low
   input wire core_req_t coreReq, // Core requests
   input wire core_ans_t coreAns, // Core answers
   input wire logic [NSRC-1:0] wakeEvent, // Sleep-capable events
   input wire logic [NSRC-1:0] clockedEvent, // Clock-bound events
   input wire logic wdtTimeout, // Watchdog expiry
   input wire logic watchdog_enable_fuse, // Watchdog fuse
   input wire logic master_clear_pin, // Master clear level
   input wire logic wdtClear, // Watchdog clear pulse
   input wire logic oscRun, // Oscillator on
   input wire logic pinHold, // Pin hold
   input wire logic deviceReset, // Full reset request
   input wire logic masterClearOe // Master clear drive enable
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   // Pin and entry checks
   a_master_clear_pin_not_driven: assert property (!masterClearOe) else $error("master clear driven");
   a_sleep_stops_osc: assert property ($fell(oscRun) |-> $past(coreReq.sleepInstr))
      else $error("oscillator stopped without sleep");
   a_entry_clears_wdt: assert property ($fell(oscRun) |-> $past(wdtClear))
      else $error("sleep entry without watchdog clear");
   a_pins_held: assert property (!oscRun |-> pinHold) else $error("pins not held in sleep");
   a_prefetch_next: assert property ($fell(oscRun) |=> coreAns.prefetchAddr == $past(coreReq.pc, 2) + 13'd1)
      else $error("prefetch address wrong");
   ////////////////////////////////////////
   // Exit checks
   a_exit_clears_wdt: assert property (coreAns.resumeStrobe |-> $past(wdtClear))
      else $error("resume without watchdog clear");
   a_osc_before_run: assert property (coreAns.resumeStrobe |-> oscRun && $past(oscRun))
      else $error("resume before oscillator restart");
   a_vector_addr: assert property (coreAns.vectorTake |-> coreAns.resumeStrobe && coreAns.vectorAddr == 13'h0004)
      else $error("vector answer wrong");
   a_clocked_no_wake: assert property (!oscRun && !$past(oscRun) && clockedEvent != '0 && wakeEvent == '0
      && !wdtTimeout && master_clear_pin |=> !oscRun) else $error("clocked event woke device");
   a_wdt_wakes: assert property (!oscRun && wdtTimeout && watchdog_enable_fuse && master_clear_pin
      |-> ##[8:16] coreAns.resumeStrobe) else $error("watchdog wake missing");
   a_master_clear_pin_resets: assert property (!oscRun && !master_clear_pin |-> deviceReset)
      else $error("master clear in sleep without reset");
endmodule : sleep_wake_monitor

// >>> sleep_core_model.sv
/*
 Processor core model: issues watchdog-clear and sleep instructions.
 Assumes the testbench calls its tasks right after a clock edge.
*/
`timescale 1ns/10ps
module sleep_core_model
   import sleep_wake_pkg::*;
(
   input wire logic clk_sys, // System clock
   output core_req_t coreReq, // Instruction requests
   input wire core_ans_t coreAns // Answers, watched by the bench
);
   initial coreReq = '0;
   // One-cycle watchdog clear instruction
   task automatic clr_wdt();
      @(posedge clk_sys);
      coreReq.wdtClearInstr <= 1'b1;
      @(posedge clk_sys);
      coreReq.wdtClearInstr <= 1'b0;
   endtask : clr_wdt
   // Sleep instruction, always preceded by a watchdog clear
   task automatic do_sleep(input logic [12:0] p);
      clr_wdt();
      coreReq.pc <= p;
      coreReq.sleepInstr <= 1'b1;
      @(posedge clk_sys);
      coreReq.sleepInstr <= 1'b0;
      coreReq.pc <= ~p; // Stale address made visibly different
   endtask : do_sleep
endmodule : sleep_core_model

// >>> tb_top.sv
/*
 Self-checking testbench for the sleep/wake controller.
 Assumes the package, core model and checker are compiled first.
*/
`timescale 1ns/10ps
module tb_top
   import sleep_wake_pkg::*;
;
   logic clk_sys, reset_n, wdtTimeout, watchdog_enable_fuse, master_clear_pin, high_voltage_entry_level;
   logic serial_prog_data, serial_prog_clock, code_protect_bit, protectOffReq, progWrite, progDataOut;
   logic progDataOe, bulkErase, wdtClear, oscRun, pinHold, deviceReset, masterClearOut, masterClearOe;
   logic [NSRC-1:0] wakeEvent, clockedEvent; // Wake sources
   logic [13:0] progAddr, progWdata, flashRdata, progRdata; // Programming side
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   core_req_t coreReq;
   core_ans_t coreAns;
   logic [33:0] rdQ[$], wrQ[$], rsQ[$], erQ[$]; // Expected-result notes
   int error_cnt = 0, n_compared = 0;
   logic [31:0] rngState = 32'h0001_3ACE; // Xorshift seed
   logic [12:0] pc;
   sleep_wake_controller u_sleep_wake_controller (.clk_sys, .reset_n, .coreReq, .coreAns, .wakeEvent,
      .clockedEvent, .wdtTimeout, .watchdog_enable_fuse, .master_clear_pin, .high_voltage_entry_level,
      .serial_prog_data, .serial_prog_clock, .code_protect_bit, .protectOffReq, .progAddr, .progWdata,
      .progWrite, .flashRdata, .progRdata, .progDataOut, .progDataOe, .bulkErase, .wdtClear, .oscRun, .pinHold,
      .deviceReset, .masterClearOut, .masterClearOe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   sleep_core_model u_sleep_core_model (.clk_sys, .coreReq, .coreAns);
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////
   // Helpers
   function automatic logic [31:0] rnd();
      rngState ^= rngState << 13;
      rngState ^= rngState >> 17;
      rngState ^= rngState << 5;
      return rngState;
   endfunction : rnd
   task automatic chk(input logic [33:0] e, input logic [33:0] g, input string m);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t %s exp %h got %h", $time, m, e, g);
      end
   endtask : chk
   task automatic finish_test();
      chk(34'(rdQ.size() + wrQ.size() + rsQ.size() + erQ.size()), '0, "results never seen");
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      wrQ.push_back(34'(er));
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 100);
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n = 0;
      rdQ.push_back({er, d});
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 100);
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic pulse(input logic [NSRC-1:0] w, input logic [NSRC-1:0] c, input logic t);
      @(posedge clk_sys);
      wakeEvent <= w;
      clockedEvent <= c;
      wdtTimeout <= t;
      @(posedge clk_sys);
      wakeEvent <= '0;
      clockedEvent <= '0;
      wdtTimeout <= 1'b0;
   endtask : pulse
   task automatic nap(input logic vec, input bit note);
      pc = 13'(rnd());
      if (note)
         rsQ.push_back(34'({vec, pc + 13'd1}));
      u_sleep_core_model.do_sleep(pc);
   endtask : nap
   task automatic wait_resume();
      int n = 0;
      while (!coreAns.resumeStrobe && n < 40) begin
         @(posedge clk_sys);
         n++;
      end
      @(posedge clk_sys);
   endtask : wait_resume
   ////////////////////////////////////////
   // Result watcher: oldest note against each result
   always @(posedge clk_sys) begin
      if (s_axi_bvalid && s_axi_bready)
         chk(wrQ.size() ? wrQ.pop_front() : 'x, 34'(s_axi_bresp), "write response");
      if (s_axi_rvalid && s_axi_rready)
         chk(rdQ.size() ? rdQ.pop_front() : 'x, {s_axi_rresp, s_axi_rdata}, "read data");
      if (coreAns.resumeStrobe)
         chk(rsQ.size() ? rsQ.pop_front() : 'x, 34'({coreAns.vectorTake, coreAns.prefetchAddr}), "resume");
      if (bulkErase)
         chk(erQ.size() ? erQ.pop_front() : 'x, 34'd1, "bulk erase");
   end
   initial begin
      #(100 * 6000);
      error_cnt++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
   ////////////////////////////////////////
   // Main sequence
   initial begin
      {reset_n, wdtTimeout, high_voltage_entry_level, serial_prog_data, serial_prog_clock} = '0;
      {protectOffReq, progWrite, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {wakeEvent, clockedEvent, progAddr, progWdata, flashRdata, s_axi_awaddr, s_axi_araddr} = '0;
      {watchdog_enable_fuse, master_clear_pin, code_protect_bit} = 3'b111;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      axi_rd(OFF_OPTION, 32'h0000_00FF, RESP_OKAY);
      axi_rd(OFF_STATUS, 32'h0000_0013, RESP_OKAY);
      axi_rd(8'h40, 32'h0000_0000, RESP_SLVERR);
      axi_wr(8'h40, 32'h0000_0001, RESP_SLVERR);
      rv = rnd();
      axi_wr(OFF_OPTION, rv, RESP_OKAY);
      axi_rd(OFF_OPTION, {24'h00_0000, rv[7:0]}, RESP_OKAY);
      $display("registers done");
      nap(1'b0, 1'b1);
      pulse('0, 6'h3F, 1'b0);
      pulse('0, '0, 1'b1);
      wait_resume();
      axi_rd(OFF_STATUS, 32'h0000_0010, RESP_OKAY);
      $display("watchdog wake done");
      axi_wr(OFF_IRQEN, 32'h0000_00A0, RESP_OKAY);
      nap(1'b1, 1'b1);
      pulse(6'h01, '0, 1'b0);
      axi_rd(OFF_IRQFLAG, 32'h0000_0001, RESP_OKAY);
      pulse(6'h20, '0, 1'b0);
      wait_resume();
      axi_rd(OFF_STATUS, 32'h0000_0012, RESP_OKAY);
      $display("interrupt wake done");
      nap(1'b0, 1'b0);
      repeat (20) @(posedge clk_sys);
      axi_rd(OFF_STATUS, 32'h0000_0013, RESP_OKAY);
      axi_wr(OFF_IRQFLAG, 32'h0000_0021, RESP_OKAY);
      axi_rd(OFF_IRQFLAG, 32'h0000_0000, RESP_OKAY);
      axi_wr(OFF_IRQEN, 32'h0000_0010, RESP_OKAY);
      fork
         nap(1'b0, 1'b1);
         begin
            @(posedge clk_sys);
            pulse(6'h10, '0, 1'b0);
         end
      join
      wait_resume();
      axi_rd(OFF_STATUS, 32'h0000_0012, RESP_OKAY);
      $display("no-op and late wake done");
      axi_wr(OFF_IRQEN, 32'h0000_0000, RESP_OKAY);
      nap(1'b0, 1'b0);
      master_clear_pin <= 1'b0;
      repeat (3) @(posedge clk_sys);
      master_clear_pin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      $display("master clear done");
      high_voltage_entry_level <= 1'b1;
      axi_rd(OFF_PROG, 32'h0000_0003, RESP_OKAY);
      rv = rnd();
      progAddr <= ID_BASE + 14'd1;
      progWdata <= rv[13:0];
      progWrite <= 1'b1;
      @(posedge clk_sys);
      progWrite <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk(34'(rv[13:0]), 34'(progRdata), "id word");
      progAddr <= 14'h0010;
      flashRdata <= 14'(rnd());
      repeat (2) @(posedge clk_sys);
      chk(34'(flashRdata), 34'(progRdata), "flash read");
      chk(34'({1'b1, flashRdata[0]}), 34'({progDataOe, progDataOut}), "data pin");
      code_protect_bit <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk('0, 34'(progRdata), "flash hidden");
      erQ.push_back(34'd1);
      protectOffReq <= 1'b1;
      @(posedge clk_sys);
      protectOffReq <= 1'b0;
      high_voltage_entry_level <= 1'b0;
      progAddr <= ID_BASE + 14'd1;
      repeat (4) @(posedge clk_sys);
      chk('0, 34'(progRdata), "id hidden");
      $display("programming done");
      finish_test();
   end
endmodule : tb_top
bind sleep_wake_controller sleep_wake_monitor u_sleep_wake_monitor (.clk_sys, .reset_n, .coreReq, .coreAns,
   .wakeEvent, .clockedEvent, .wdtTimeout, .watchdog_enable_fuse, .master_clear_pin, .wdtClear, .oscRun,
   .pinHold, .deviceReset, .masterClearOe);
